// *** include/chrm_params.svh ***
// Constants of the channel re-map register bank: command code, reset value, bus addresses.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CHRM_PARAMS_SVH
`define CHRM_PARAMS_SVH

// Command code that selects the map byte.
`define CHRM_CMD_MAP 8'h26
// Map value after power-on: identity mapping.
`define CHRM_MAP_RESET 8'hE4
// Value returned when another command code is read.
`define CHRM_RD_NONE 8'h00
// Bus target addresses of the two four-channel groups.
`define CHRM_ADDR_G0 7'h20
`define CHRM_ADDR_G1 7'h21
// Serial bit count that marks a complete byte.
`define CHRM_BYTE_BITS 4'h8

`endif

// *** include/chrm_pkg.sv ***
// Types and decoding helpers shared by the re-map register bank and its bus engine.
// Assumes chrm_params.svh is on the include path.
`include "chrm_params.svh"

package chrm_pkg;

    typedef logic [7:0] chrm_byte_t;
    typedef logic [1:0] chrm_code_t;
    typedef logic [3:0] chrm_nib_t;
    typedef logic [7:0] chrm_oct_t;

    // Serial engine states, Gray coded along the write path.
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_ADDR  = 4'h1,
        ST_ACK_A = 4'h3,
        ST_CMD   = 4'h2,
        ST_ACK_C = 4'h6,
        ST_WDAT  = 4'h7,
        ST_ACK_W = 4'h5,
        ST_RDAT  = 4'h4,
        ST_RACK  = 4'hC
    } chrm_state_t;

    // Physical channel code of one logical channel.
    function automatic chrm_code_t chrm_code_of(input chrm_byte_t map, input int idx);
        chrm_code_t code;
        code = map[2*idx +: 2];
        return code;
    endfunction : chrm_code_of

    // True when the four codes are all different.
    function automatic logic chrm_distinct(input chrm_byte_t map);
        chrm_nib_t seen;
        seen = 4'h0;
        for (int i = 0; i < 4; i++) begin
            seen[chrm_code_of(map, i)] = 1'b1;
        end
        return &seen;
    endfunction : chrm_distinct

endpackage : chrm_pkg

// *** include/chrm_reg_if.sv ***
// Register access path between the serial engine and one group's map bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface chrm_reg_if;
    logic wr_en;
    chrm_pkg::chrm_byte_t wr_data;
    chrm_pkg::chrm_byte_t map;

    modport engine (output wr_en, output wr_data, input map);
    modport bank (input wr_en, input wr_data, output map);
endinterface : chrm_reg_if

// *** rtl/chrm_bank.sv ***
// Map byte of one four-channel group and the routing it steers.
// Assumes rst_n is the synchronised power-on reset and all inputs are on clk.
`timescale 1ns/1ps
`include "chrm_params.svh"

module chrm_bank (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst_n,
    // Register access
    chrm_reg_if.bank regs,
    // Channel state and routed signals
    input wire chrm_pkg::chrm_nib_t chan_on,
    input wire chrm_pkg::chrm_nib_t gate_log,
    output chrm_pkg::chrm_nib_t gate_phys,
    input wire chrm_pkg::chrm_nib_t sense_phys,
    output chrm_pkg::chrm_nib_t sense_log
);
    import chrm_pkg::*;

    logic all_off;
    logic accept;

    assign all_off = ~|chan_on; // R7
    assign accept = regs.wr_en && all_off && chrm_distinct(regs.wr_data); // R7 R9

    // ******************************************
    // Map register
    // ******************************************
    // Only power-on resets it to E4h; the pin reset never reaches this flop.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regs.map <= `CHRM_MAP_RESET; // R5 R10
        end else if (accept) begin
            regs.map <= regs.wr_data; // R1 R2 R8
        end
    end

    // ******************************************
    // Routing within the group
    // ******************************************
    // Indices stay inside this group, so no path crosses groups.
    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_route
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    gate_phys[p] <= 1'b0;
                    sense_log[p] <= 1'b0;
                end else begin
                    gate_phys[p] <= |(gate_log & {chrm_code_of(regs.map, 3) == 2'(p),
                        chrm_code_of(regs.map, 2) == 2'(p), chrm_code_of(regs.map, 1) == 2'(p),
                        chrm_code_of(regs.map, 0) == 2'(p)}); // R3 R4 R6
                    sense_log[p] <= sense_phys[chrm_code_of(regs.map, p)]; // R3 R4 R6
                end
            end
        end
    endgenerate

    // ******************************************
    // Checks
    // ******************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_map_accept: assert property (regs.wr_en && all_off && chrm_distinct(regs.wr_data)
        |=> regs.map == $past(regs.wr_data)) else $error("Valid map write not stored."); // R1
    a_map_busy: assert property (regs.wr_en && !all_off |=> $stable(regs.map))
        else $error("Map changed while a channel was on."); // R8
    a_map_dup: assert property (regs.wr_en && !chrm_distinct(regs.wr_data) |=> $stable(regs.map))
        else $error("Map took duplicate codes."); // R9
    a_map_perm: assert property (chrm_distinct(regs.map))
        else $error("Map is not a permutation."); // R6
    a_route_gate: assert property (1'b1 |=> gate_phys[$past(regs.map[1:0])] == $past(gate_log[0]))
        else $error("Logical channel one not routed."); // R4
endmodule : chrm_bank

// *** rtl/chrm_top.sv ***
// Serial management target holding the channel re-map byte of both four-channel groups.
// Assumes scl and sda_in come from pins; chan_on, gate_log and sense_phys come from logic on clk.
`timescale 1ns/1ps
`include "chrm_params.svh"

// Operation
// [R1] Map byte is read/write under command 26h, one data byte per transfer; a host ACK after a read byte gets the byte sent again.
// [R2] Bits 7:6, 5:4, 3:2, 1:0 serve logical channels 4, 3, 2, 1.
// [R3] Code 00..11 picks physical channel 1..4.
// [R4] Each field steers the pin set used by its logical channel.
// [R5] Power-on value is E4h, the identity mapping.
// [R6] Re-mapping stays inside channels 1-4 or 5-8.
// [R7] Write lands only while every channel of the group is off.
// [R8] Rejected write leaves the map and routing unchanged.
// [R9] Write with duplicate codes is ignored entirely.
// [R10] Reset pin leaves the map alone; only power-on restores it.
// [R11] Host should run detection and classification before powering re-mapped channels.
// [R12] Each group has its own map byte behind its own bus address.
module chrm_top (
    // Clock and resets
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reset_pin_n,
    // Serial management bus
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Channel state and routed signals
    input wire chrm_pkg::chrm_oct_t chan_on,
    input wire chrm_pkg::chrm_oct_t gate_log,
    output chrm_pkg::chrm_oct_t gate_phys,
    input wire chrm_pkg::chrm_oct_t sense_phys,
    output chrm_pkg::chrm_oct_t sense_log
);
    import chrm_pkg::*;

    logic rst_q1;
    logic rst_n;
    logic prst_q1;
    logic prst_n;
    logic scl_q1;
    logic scl_s;
    logic scl_d;
    logic sda_q1;
    logic sda_s;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    chrm_state_t state;
    logic [3:0] cnt;
    chrm_byte_t shreg;
    chrm_byte_t cmd;
    chrm_byte_t tx;
    chrm_byte_t rd_byte;
    logic grp;
    logic rw;
    logic wr_pulse;
    chrm_byte_t wr_byte;

    // ******************************************
    // Reset and pin synchronisers
    // ******************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prst_q1 <= 1'b1;
            prst_n <= 1'b1;
            scl_q1 <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_q1 <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            prst_q1 <= reset_pin_n;
            prst_n <= prst_q1;
            scl_q1 <= scl;
            scl_s <= scl_q1;
            scl_d <= scl_s;
            sda_q1 <= sda_in;
            sda_s <= sda_q1;
            sda_d <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det = scl_s && scl_d && !sda_d && sda_s;
    // The line is only ever pulled low; release is done by dropping the enable.
    assign sda_out = 1'b0;

    // ******************************************
    // Serial engine
    // ******************************************
    // The pin reset returns the engine to idle but never touches the map banks.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            sda_oe <= 1'b0;
            cmd <= 8'h00;
            tx <= 8'h00;
            grp <= 1'b0;
            rw <= 1'b0;
        end else if (!prst_n || stop_det) begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
        end else if (start_det) begin
            state <= ST_ADDR;
            cnt <= 4'h0;
            sda_oe <= 1'b0;
        end else if (scl_rise) begin
            if (state == ST_ADDR || state == ST_CMD || state == ST_WDAT) begin
                cnt <= cnt + 4'h1;
            end else if (state == ST_RACK && sda_s) begin
                state <= ST_IDLE;
            end
        end else if (scl_fall) begin
            unique case (state)
                ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                ST_ADDR: begin
                    if (cnt == `CHRM_BYTE_BITS) begin
                        if (shreg[7:1] == `CHRM_ADDR_G0 || shreg[7:1] == `CHRM_ADDR_G1) begin
                            grp <= (shreg[7:1] == `CHRM_ADDR_G1); // R12
                            rw <= shreg[0];
                            state <= ST_ACK_A;
                            sda_oe <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_ACK_A, ST_RACK: begin
                    if (rw) begin
                        state <= ST_RDAT;
                        sda_oe <= ~rd_byte[7]; // R1
                        tx <= {rd_byte[6:0], 1'b0};
                        cnt <= 4'h1;
                    end else begin
                        state <= ST_CMD;
                        sda_oe <= 1'b0;
                        cnt <= 4'h0;
                    end
                end
                ST_RDAT: begin
                    if (cnt == `CHRM_BYTE_BITS) begin
                        sda_oe <= 1'b0;
                        state <= ST_RACK;
                    end else begin
                        sda_oe <= ~tx[7];
                        tx <= {tx[6:0], 1'b0};
                        cnt <= cnt + 4'h1;
                    end
                end
                ST_CMD: begin
                    if (cnt == `CHRM_BYTE_BITS) begin
                        cmd <= shreg;
                        state <= ST_ACK_C;
                        sda_oe <= 1'b1;
                    end
                end
                ST_ACK_C: begin
                    sda_oe <= 1'b0;
                    cnt <= 4'h0;
                    state <= ST_WDAT;
                end
                ST_WDAT: begin
                    if (cnt == `CHRM_BYTE_BITS) begin
                        state <= ST_ACK_W;
                        sda_oe <= 1'b1;
                    end
                end
                ST_ACK_W: begin
                    // A second data byte in one transfer is refused with a NACK.
                    sda_oe <= 1'b0;
                    state <= ST_IDLE; // R1
                end
                default: begin
                    state <= ST_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg <= 8'h00;
        end else if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
        end
    end

    // ******************************************
    // Register access
    // ******************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pulse <= 1'b0;
            wr_byte <= 8'h00;
        end else begin
            wr_pulse <= prst_n && !stop_det && !start_det && scl_fall && state == ST_WDAT
                && cnt == `CHRM_BYTE_BITS && cmd == `CHRM_CMD_MAP; // R1
            wr_byte <= shreg;
        end
    end

    chrm_reg_if reg_if[2] ();

    always_comb begin
        if (cmd != `CHRM_CMD_MAP) begin
            rd_byte = `CHRM_RD_NONE;
        end else if (grp) begin
            rd_byte = reg_if[1].map; // R12
        end else begin
            rd_byte = reg_if[0].map;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_group
            assign reg_if[g].wr_en = wr_pulse && (grp == 1'(g)); // R12
            assign reg_if[g].wr_data = wr_byte;
            chrm_bank u_bank (
                .clk(clk),
                .rst_n(rst_n),
                .regs(reg_if[g]),
                .chan_on(chan_on[4*g +: 4]), // R6 R7
                .gate_log(gate_log[4*g +: 4]),
                .gate_phys(gate_phys[4*g +: 4]),
                .sense_phys(sense_phys[4*g +: 4]),
                .sense_log(sense_log[4*g +: 4])
            );
        end
    endgenerate

    // ******************************************
    // Checks
    // ******************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_addr_g1;
        prst_n && !stop_det && !start_det && scl_fall && state == ST_ADDR
            && cnt == `CHRM_BYTE_BITS && shreg[7:1] == `CHRM_ADDR_G1;
    endsequence

    sequence s_map_write;
        prst_n && !stop_det && !start_det && scl_fall && state == ST_WDAT
            && cnt == `CHRM_BYTE_BITS && cmd == `CHRM_CMD_MAP;
    endsequence

    a_addr_ack: assert property (s_addr_g1 |=> sda_oe && state == ST_ACK_A && grp)
        else $error("Group address not acknowledged."); // R12
    a_map_strobe: assert property (s_map_write |=> wr_pulse ##1 !wr_pulse)
        else $error("Map write strobe missing or stretched."); // R1
    a_other_cmd: assert property (cmd != `CHRM_CMD_MAP |=> !wr_pulse)
        else $error("Write strobe for another command."); // R1
    a_pin_keeps: assert property (!prst_n && !$past(prst_n) |=> $stable(reg_if[0].map) && $stable(reg_if[1].map))
        else $error("Pin reset altered the map."); // R10
    a_read_bit: assert property (scl_fall && state == ST_ACK_A && rw && prst_n && !stop_det && !start_det
        |=> sda_oe == !$past(rd_byte[7])) else $error("Read data bit wrong."); // R1
endmodule : chrm_top

// *** tb/chrm_host.sv ***
// Bus master model standing in for the host processor on the management bus.
// Assumes a pull-up on the data line and a target that samples the bus on clk.
`timescale 1ns/1ps

module chrm_host (
    // Clock
    input wire logic clk,
    // Bus pins
    input wire logic sda_oe,
    input wire logic sda_out,
    output logic scl,
    output logic sda_line
);
    logic pull;

    // The line idles high through the pull-up; either party may pull it low.
    assign sda_line = ~(pull | (sda_oe & ~sda_out));

    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end

    // ****************************************
    // Bus cycles
    // ****************************************
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : hold

    // Phases of four cycles leave room for the two-flop sampling in the target.
    task automatic bit_io(input logic b, output logic r);
        pull = ~b;
        hold(4);
        scl = 1'b1;
        hold(4);
        r = sda_line;
        hold(4);
        scl = 1'b0;
        hold(4);
    endtask : bit_io

    task automatic start;
        pull = 1'b0;
        hold(4);
        scl = 1'b1;
        hold(8);
        pull = 1'b1;
        hold(8);
        scl = 1'b0;
        hold(4);
    endtask : start

    task automatic stop;
        pull = 1'b1;
        hold(4);
        scl = 1'b1;
        hold(8);
        pull = 1'b0;
        hold(8);
    endtask : stop

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wbyte

    task automatic rbyte(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(1'b1, r);
    endtask : rbyte

    task automatic write_map(input logic [6:0] addr, input logic [7:0] cmd, input logic [7:0] d, output logic ack);
        logic a1;
        logic a2;
        logic a3;
        start();
        wbyte({addr, 1'b0}, a1);
        wbyte(cmd, a2);
        wbyte(d, a3);
        stop();
        ack = a1 & a2 & a3;
    endtask : write_map

    task automatic read_map(input logic [6:0] addr, input logic [7:0] cmd, output logic [7:0] d);
        logic a;
        start();
        wbyte({addr, 1'b0}, a);
        wbyte(cmd, a);
        start();
        wbyte({addr, 1'b1}, a);
        rbyte(d);
        stop();
    endtask : read_map
endmodule : chrm_host

// *** tb/testbench.sv ***
// Self-checking bench for the re-map register bank and its routing.
// Assumes the design package, interface and modules are compiled first.
`timescale 1ns/1ps
`include "chrm_params.svh"

module testbench;
    logic clk = 1'b0;
    logic arst_n;
    logic reset_pin_n;
    logic scl;
    logic sda_line;
    logic sda_oe;
    logic sda_out;
    logic [7:0] chan_on;
    logic [7:0] gate_log;
    logic [7:0] gate_phys;
    logic [7:0] sense_phys;
    logic [7:0] sense_log;
    logic [15:0] mdl;
    logic [7:0] res_val;
    logic [7:0] exp_q[$];
    int miscompares = 0;
    int n_tests = 0;
    int k;
    int j;
    logic [7:0] d;
    event shown;

    always #20 clk = ~clk;

    chrm_top i_dut (.clk(clk), .arst_n(arst_n), .reset_pin_n(reset_pin_n), .scl(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .chan_on(chan_on), .gate_log(gate_log), .gate_phys(gate_phys),
        .sense_phys(sense_phys), .sense_log(sense_log));
    chrm_host i_host (.clk(clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda_line(sda_line));

    // ****************************************
    // Checking
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] expv);
        n_tests++;
        if (seen !== expv) begin
            miscompares++;
            $display("[ERR] %0t result mismatch: saw %h expected %h", $time, seen, expv);
        end
    endtask : check

    task automatic test_done;
        if (miscompares == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    initial begin
        forever begin
            @(shown);
            check(res_val, exp_q.pop_front());
        end
    end

    task automatic show(input logic [7:0] v);
        res_val = v;
        ->shown;
        // Waiting for the next edge keeps every input change at the same offset after it.
        @(posedge clk);
        #2;
    endtask : show

    function automatic logic uniq(input logic [7:0] m);
        logic [3:0] seen;
        seen = 4'h0;
        for (int i = 0; i < 4; i++) seen[m[2*i +: 2]] = 1'b1;
        return seen == 4'hF;
    endfunction : uniq

    // Forward steers logical gate drive onto physical pins; otherwise sense comes back.
    function automatic logic [7:0] route(input logic [15:0] m, input logic [7:0] v, input logic fwd);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (fwd) r[4*(i/4) + m[2*i +: 2]] = v[i];
            else r[i] = v[4*(i/4) + m[2*i +: 2]];
        end
        return r;
    endfunction : route

    task automatic rd_chk(input int g);
        logic [7:0] v;
        i_host.read_map(g ? `CHRM_ADDR_G1 : `CHRM_ADDR_G0, `CHRM_CMD_MAP, v);
        exp_q.push_back(mdl[8*g +: 8]);
        show(v);
    endtask : rd_chk

    task automatic route_chk;
        gate_log = $urandom;
        sense_phys = $urandom;
        repeat (3) @(posedge clk);
        #2;
        exp_q.push_back(route(mdl, gate_log, 1'b1));
        show(gate_phys);
        exp_q.push_back(route(mdl, sense_phys, 1'b0));
        show(sense_log);
    endtask : route_chk

    task automatic wr_chk(input int g, input logic [7:0] v);
        logic ack;
        i_host.write_map(g ? `CHRM_ADDR_G1 : `CHRM_ADDR_G0, `CHRM_CMD_MAP, v, ack);
        exp_q.push_back(8'h01);
        show({7'h00, ack});
        if (chan_on[4*g +: 4] == 4'h0 && uniq(v)) mdl[8*g +: 8] = v;
        rd_chk(g);
        // Routing is confirmed before any channel of the group is powered again.
        route_chk();
    endtask : wr_chk

    initial begin
        logic ack;
        k = $urandom(31412);
        arst_n = 1'b0;
        reset_pin_n = 1'b1;
        chan_on = 8'h00;
        gate_log = 8'h00;
        sense_phys = 8'h00;
        mdl = 16'hE4E4;
        repeat (20) @(posedge clk);
        #2 arst_n = 1'b1;
        repeat (6) @(posedge clk);
        #2;
        rd_chk(0);
        rd_chk(1);
        route_chk();
        wr_chk(0, 8'h1B);
        wr_chk(1, 8'h93);
        chan_on = 8'h04;
        wr_chk(0, 8'h4E);
        wr_chk(1, 8'h4E);
        chan_on = 8'h80;
        wr_chk(1, 8'hE4);
        chan_on = 8'h00;
        wr_chk(0, 8'hE5);
        repeat (8) begin
            chan_on = ($urandom % 2) ? 8'h00 : 8'h01 << ($urandom % 8);
            k = $urandom % 4;
            j = $urandom % 4;
            d = mdl[7:0];
            d[2*k +: 2] = mdl[2*j +: 2];
            d[2*j +: 2] = mdl[2*k +: 2];
            if ($urandom % 3 == 0) d = $urandom;
            wr_chk($urandom % 2, d);
        end
        chan_on = 8'h00;
        i_host.write_map(7'h22, `CHRM_CMD_MAP, 8'h1B, ack);
        exp_q.push_back(8'h00);
        show({7'h00, ack});
        // Another command code is acknowledged but must leave the map alone.
        i_host.write_map(`CHRM_ADDR_G0, 8'h27, 8'h1B, ack);
        exp_q.push_back(8'h01);
        show({7'h00, ack});
        i_host.read_map(`CHRM_ADDR_G0, 8'h27, d);
        exp_q.push_back(`CHRM_RD_NONE);
        show(d);
        rd_chk(0);
        reset_pin_n = 1'b0;
        repeat (4) @(posedge clk);
        #2 reset_pin_n = 1'b1;
        repeat (6) @(posedge clk);
        #2;
        rd_chk(0);
        rd_chk(1);
        arst_n = 1'b0;
        repeat (4) @(posedge clk);
        #2 arst_n = 1'b1;
        mdl = 16'hE4E4;
        repeat (6) @(posedge clk);
        #2;
        rd_chk(0);
        rd_chk(1);
        route_chk();
        repeat (4) @(posedge clk);
        test_done();
    end

    // Reckoned as roughly three times the expected run of about 22k cycles.
    initial begin
        #3_000_000;
        miscompares++;
        test_done();
    end
endmodule : testbench
